// ==== rtl/epc_host.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Per-chip selects, one common read gate
// - Drive address and eight data bits parallel
// - One select pulse, 50 ms, below 55
// - Select never held low statically
// - Every location gets its own pulse
// - Mask of several chips pulsed together
// - Verify after delay with select, gate low
module epc_host #(
    parameter int PULSE_CYC = epc_pkg::PGM_PULSE_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic req_valid,
    output logic req_ready,
    input wire epc_pkg::epc_op_t req_op,
    input wire logic [epc_pkg::CHIP_N-1:0] req_chips,
    input wire logic [epc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [epc_pkg::DATA_W-1:0] req_data,
    output logic rsp_valid,
    output logic [epc_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_mismatch,
    output logic [epc_pkg::ADDR_W-1:0] word_address_bits,
    output logic [epc_pkg::CHIP_N-1:0] chip_sel_n,
    output logic out_gate_n,
    output logic prog_volt_en,
    input wire logic [epc_pkg::DATA_W-1:0] data_pins_in,
    output logic [epc_pkg::DATA_W-1:0] data_pins_out,
    output logic data_pins_oe
);
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_PULSE, ST_RECOVER, ST_ACCESS,
        ST_FLOAT} epc_state_t;

    epc_state_t state;
    epc_pkg::epc_op_t op;
    logic [epc_pkg::CHIP_N-1:0] chips;
    logic [epc_pkg::DATA_W-1:0] wdata;
    logic tmr_load;
    logic [epc_pkg::CNT_W-1:0] tmr_count;
    logic tmr_busy;
    logic tmr_done;
    logic take;

    function automatic logic [epc_pkg::CNT_W-1:0] cyc(input int n);
        return epc_pkg::CNT_W'(n);
    endfunction

    assign req_ready = (state == ST_IDLE);
    assign take = req_valid && req_ready;

    epc_timer u_timer (
        .core_clk(core_clk),
        .resetn(resetn),
        .load(tmr_load),
        .count(tmr_count),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    always_comb
    begin
        tmr_load = 1'b0;
        tmr_count = '0;
        if (take)
        begin
            tmr_load = 1'b1;
            tmr_count = (req_op == epc_pkg::EPC_OP_PROG) ? cyc(epc_pkg::SETUP_CYC)
                : cyc(epc_pkg::ACCESS_CYC);
        end
        else if (state == ST_SETUP && tmr_done)
        begin
            tmr_load = 1'b1;
            tmr_count = cyc(PULSE_CYC);
        end
        else if ((state == ST_PULSE || state == ST_ACCESS) && tmr_done)
        begin
            tmr_load = 1'b1;
            tmr_count = cyc(epc_pkg::FLOAT_CYC);
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_IDLE;
            op <= epc_pkg::EPC_OP_READ;
            chips <= '0;
            wdata <= epc_pkg::ERASED_WORD;
            word_address_bits <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (take)
                    begin
                        op <= req_op;
                        chips <= req_chips;
                        wdata <= req_data;
                        word_address_bits <= req_addr;
                        state <= (req_op == epc_pkg::EPC_OP_PROG) ? ST_SETUP : ST_ACCESS;
                    end
                ST_SETUP:
                    if (tmr_done)
                        state <= ST_PULSE;
                ST_PULSE:
                    if (tmr_done)
                        state <= ST_RECOVER;
                ST_RECOVER:
                    if (tmr_done)
                        state <= ST_IDLE;
                ST_ACCESS:
                    if (tmr_done)
                        state <= ST_FLOAT;
                ST_FLOAT:
                    if (tmr_done)
                        state <= ST_IDLE;
            endcase
        end
    end

    // Pin levels all registered so no glitch reaches the device
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            chip_sel_n <= '1;
            out_gate_n <= 1'b1;
            prog_volt_en <= 1'b0;
            data_pins_out <= '0;
            data_pins_oe <= 1'b0;
        end
        else
        begin
            // Standby for every chip unless selected below
            chip_sel_n <= '1;
            out_gate_n <= 1'b1;
            prog_volt_en <= 1'b0;
            data_pins_oe <= 1'b0;
            if (op == epc_pkg::EPC_OP_PROG && (state == ST_SETUP || state == ST_PULSE
                || state == ST_RECOVER) && !(state == ST_RECOVER && tmr_done))
            begin
                prog_volt_en <= 1'b1;
                data_pins_oe <= 1'b1;
                data_pins_out <= wdata;
                if (state == ST_PULSE && !tmr_done)
                    chip_sel_n <= ~chips;
            end
            else if (state == ST_ACCESS && !tmr_done)
            begin
                // Only the first chip of the mask is read, to avoid contention
                chip_sel_n <= ~(chips & (~chips + 1'b1));
                out_gate_n <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            rsp_mismatch <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            if (state == ST_ACCESS && tmr_done)
            begin
                rsp_valid <= 1'b1;
                rsp_data <= data_pins_in;
                rsp_mismatch <= (op == epc_pkg::EPC_OP_VERIFY) && (data_pins_in != wdata);
            end
        end
    end

    // Length of the select pulse under program voltage; a stuck select would grow it
    logic [epc_pkg::CNT_W-1:0] pulse_len;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            pulse_len <= '0;
        else if (prog_volt_en && chip_sel_n != '1)
            pulse_len <= pulse_len + 1'b1;
        else
            pulse_len <= '0;
    end

    sequence s_pulse_start;
        prog_volt_en && (chip_sel_n != '1) && ($past(chip_sel_n) == '1);
    endsequence

    sequence s_access_end;
        state == ST_ACCESS && tmr_done;
    endsequence

    AST_NO_DRIVE_ON_READ: assert property (@(posedge core_clk) disable iff (!resetn)
        !out_gate_n |-> !data_pins_oe && !prog_volt_en)
        else $error("data driven while gate low");
    AST_SEL_WITH_VOLT: assert property (@(posedge core_clk) disable iff (!resetn)
        (chip_sel_n != '1) && prog_volt_en |-> data_pins_oe)
        else $error("program pulse without data");
    AST_PULSE_BOUNDED: assert property (@(posedge core_clk) disable iff (!resetn)
        s_pulse_start |-> ##1 tmr_busy)
        else $error("program pulse not timed");
    AST_PULSE_MAX: assert property (@(posedge core_clk) disable iff (!resetn)
        pulse_len <= cyc(PULSE_CYC) && pulse_len <= cyc(epc_pkg::PGM_PULSE_MAX_CYC))
        else $error("program pulse too long");
    AST_IDLE_STANDBY: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_IDLE && $past(state) == ST_IDLE |-> chip_sel_n == '1)
        else $error("chip selected while idle");
    AST_READ_RESP: assert property (@(posedge core_clk) disable iff (!resetn)
        s_access_end |=> rsp_valid)
        else $error("no response after access");
    AST_VOLT_NO_GATE: assert property (@(posedge core_clk) disable iff (!resetn)
        prog_volt_en |-> out_gate_n)
        else $error("gate low with program voltage");
    AST_ONE_RSP: assert property (@(posedge core_clk) disable iff (!resetn)
        rsp_valid |=> !rsp_valid)
        else $error("response longer than one cycle");
    AST_READY_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
        take |=> !req_ready)
        else $error("request taken twice");
endmodule

// ==== rtl/epc_pkg.sv ====
package epc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CHIP_N = 2;
    localparam int CLK_PERIOD_NS = 25;
    // Program pulse: nominal 50 ms, never above 55 ms
    localparam int PGM_PULSE_MS = 50;
    localparam int PGM_PULSE_MAX_MS = 55;
    localparam int PGM_PULSE_CYC = PGM_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PGM_PULSE_MAX_CYC = PGM_PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;
    // Read access: address/select to data, and output-gate to data
    localparam int ACCESS_NS = 550;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FLOAT_NS = 100;
    localparam int FLOAT_CYC = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Stable time of address and data before the pulse, and of program voltage
    localparam int SETUP_NS = 2000;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam logic [DATA_W-1:0] ERASED_WORD = 8'hff;
    typedef enum logic [1:0] {EPC_OP_READ, EPC_OP_PROG, EPC_OP_VERIFY} epc_op_t;
endpackage

// ==== rtl/epc_timer.sv ====
`timescale 1ns/1ps
// Down counter; done pulses one cycle when a loaded count runs out
module epc_timer (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [epc_pkg::CNT_W-1:0] count,
    output logic busy,
    output logic done
);
    logic [epc_pkg::CNT_W-1:0] cnt;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt <= '0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (load)
                cnt <= count;
            else if (cnt != '0)
            begin
                cnt <= cnt - 1'b1;
                done <= (cnt == 24'h000001);
            end
        end
    end

    assign busy = (cnt != '0) || load;
endmodule

// ==== tb/epc_eprom_model.sv ====
`timescale 1ns/1ps
// One device; the bench resolves the shared data wires
module epc_eprom_model (
    input wire logic sel_n,
    input wire logic gate_n,
    input wire logic volts,
    input wire logic [epc_pkg::ADDR_W-1:0] addr,
    input wire logic [epc_pkg::DATA_W-1:0] din,
    output logic drv,
    output logic [epc_pkg::DATA_W-1:0] dout
);
    logic [epc_pkg::DATA_W-1:0] mem [4096];
    initial foreach (mem[i]) mem[i] = epc_pkg::ERASED_WORD;
    assign drv = !sel_n && !gate_n && !volts;
    assign dout = mem[addr];
    // Word is written at the end of the select pulse; ones never come back
    always @(posedge sel_n)
        if (volts)
            mem[addr] <= mem[addr] & din;
endmodule

// ==== tb/tb_uv_eprom_read_program_port.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_uv_eprom_read_program_port;
    localparam int PULSE = 50;
    logic core_clk = 0, resetn = 0, req_valid = 0, req_ready, rsp_valid, rsp_mismatch;
    epc_pkg::epc_op_t req_op = epc_pkg::EPC_OP_READ;
    logic [1:0] req_chips = 0, chip_sel_n;
    wire [1:0] drv;
    logic [11:0] req_addr = 0, word_address_bits, a;
    logic [7:0] req_data = 0, rsp_data, data_pins_in, data_pins_out, last = 0, d;
    wire [7:0] dout [2];
    logic [7:0] img [2][4096];
    logic out_gate_n, prog_volt_en, data_pins_oe;
    logic [9:0] exp_q [$];
    int errors = 0, checks_done = 0, progs = 0, pulses = 0, cnt = 0, n;
    epc_host #(.PULSE_CYC(PULSE)) u_epc_host (.core_clk(core_clk), .resetn(resetn),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_chips(req_chips), .req_addr(req_addr), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_mismatch(rsp_mismatch),
        .word_address_bits(word_address_bits), .chip_sel_n(chip_sel_n),
        .out_gate_n(out_gate_n), .prog_volt_en(prog_volt_en), .data_pins_in(data_pins_in),
        .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
    for (genvar g = 0; g < 2; g++)
    begin : g_dev
        epc_eprom_model u_epc_eprom_model (.sel_n(chip_sel_n[g]), .gate_n(out_gate_n),
            .volts(prog_volt_en), .addr(word_address_bits), .din(data_pins_in),
            .drv(drv[g]), .dout(dout[g]));
    end
    // Released wires show a changing pattern, not a kept value
    assign data_pins_in = data_pins_oe ? data_pins_out : drv[0] ? dout[0] :
        drv[1] ? dout[1] : ~last;
    always @(posedge core_clk) last <= data_pins_in;
    initial forever #12.5 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic req(input epc_pkg::epc_op_t op, input logic [1:0] m,
        input logic [11:0] ad, input logic [7:0] dt);
        int k;
        int c;
        k = 0;
        do begin @(negedge core_clk); k++; end while (req_ready !== 1'b1 && k < 5000);
        if (k >= 5000)
        begin
            errors++;
            report_and_stop();
        end
        c = m[0] ? 0 : 1;
        if (op == epc_pkg::EPC_OP_PROG)
        begin
            for (int i = 0; i < 2; i++)
                if (m[i]) img[i][ad] = img[i][ad] & dt;
            progs++;
        end
        else
            exp_q.push_back({op == epc_pkg::EPC_OP_VERIFY, img[c][ad] !== dt, img[c][ad]});
        req_op = op;
        req_chips = m;
        req_addr = ad;
        req_data = dt;
        req_valid = 1;
        @(negedge core_clk);
        req_valid = 0;
    endtask
    always @(negedge core_clk)
    begin
        `CHK(drv[0] & drv[1] | (|drv) & data_pins_oe, 1'b0)
        if (rsp_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                `CHK(rsp_data, exp_q[0][7:0])
                `CHK(rsp_mismatch, exp_q[0][9] & exp_q[0][8])
                void'(exp_q.pop_front());
            end
        end
        if (prog_volt_en === 1'b1 && chip_sel_n !== 2'b11)
            cnt++;
        else if (cnt != 0)
        begin
            `CHK(cnt, PULSE)
            pulses++;
            cnt = 0;
        end
    end
    initial
    begin
        foreach (img[i, j]) img[i][j] = 8'hff;
        void'($urandom(32'h8851dea6));
        repeat (12) @(negedge core_clk);
        `CHK({chip_sel_n, out_gate_n, prog_volt_en, data_pins_oe}, 5'b11100)
        resetn = 1;
        req(epc_pkg::EPC_OP_READ, 2'b10, 12'hfff, 8'h00);
        req(epc_pkg::EPC_OP_VERIFY, 2'b01, 12'h000, 8'hff);
        $display("test erased done");
        for (int k = 0; k < 6; k++)
        begin
            a = (k == 0) ? 12'hfff : 12'($urandom);
            d = 8'($urandom);
            req(epc_pkg::EPC_OP_PROG, 2'(k % 3 + 1), a, d);
            req(epc_pkg::EPC_OP_PROG, 2'(k % 3 + 1), a, 8'($urandom));
            req(epc_pkg::EPC_OP_READ, 2'b01, a, 8'h00);
            req(epc_pkg::EPC_OP_READ, 2'b10, a, 8'h00);
            req(epc_pkg::EPC_OP_VERIFY, 2'b10, a, (k % 2) ? d : img[1][a]);
            $display("test program pass %0d done", k);
        end
        n = 0;
        while (exp_q.size() != 0 && n < 200)
        begin
            @(negedge core_clk);
            n++;
        end
        repeat (10) @(negedge core_clk);
        `CHK(exp_q.size(), 0)
        `CHK(pulses, progs)
        `CHK(chip_sel_n, 2'b11)
        report_and_stop();
    end
endmodule
